/* File: design/wdt_pwr_defs.vh */
// Constants for the power mode and watchdog supervisor block
// What this block does
// - Idle keeps timers and serial controller clocked, CPU stops.
// - Idle and power-down keep CPU state, registers and RAM unchanged.
// - Enabled interrupt or reset ends idle; hardware clears idle select.
// - After wake service, execution resumes after the entering instruction.
// - Power-down stops the clock to the whole core and peripherals.
// - Enabled interrupt or reset ends power-down; hardware clears its select.
// - Address latch strobe stays static during power-down.
// - Enabled watchdog resets the core when not reloaded in time.
// - Interval is (256 - reload value) times 12287 clocks.
// - Key 55H disables the watchdog; any other key enables it.
// - Key register holds 00H after reset.
// - First load-enable set enables watchdog; only reset clears that.
// - Load-enable precedes reload write; hardware then clears load-enable.
// - Reload register reads 00H after reset.
// - In emulation mode a watchdog reset resets the entire chip.
// - Power control bit 0 selects idle, bit 1 power-down; resets 00H.
`ifndef WDT_PWR_DEFS_VH
`define WDT_PWR_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_POWER_CONTROL_REGISTER_REG 6'h00
`define ADDR_KEY_REG 6'h04
`define ADDR_RELOAD_REG 6'h08
`define ADDR_STATUS_REG 6'h0C
`define ADDR_IRQ_STAT 6'h10
`define ADDR_IRQ_MASK 6'h14
`define ADDR_COUNT_REG 6'h18

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define BIT_IDLE 0
`define BIT_PDOWN 1
`define BIT_LOADEN 4
`define POWER_CONTROL_REGISTER_RESET 8'h00
`define KEY_RESET 8'h00
`define RELOAD_RESET 8'h00
`define KEY_DISABLE 8'h55
`define PRESCALE_CYCLES 14'd12287
`define PRESCALE_LAST 14'd12286
`define COUNT_TOP 9'h100
`define EV_WAKE 0
`define EV_WDRESET 1
`define EV_WIDTH 2
`define WDRST_CYCLES 4'h8

`endif

/* File: design/wdt_prescaler.v */
// Prescaler producing one tick every 12287 clocks, restartable
`timescale 1ns/1ps
`default_nettype none
`include "wdt_pwr_defs.vh"

module wdt_prescaler (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire run,
  input wire restart,
  // Tick out
  output reg tick
);

  reg [13:0] count;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Restart realigns the step so a reload gets full-length intervals
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 14'h0000;
      tick <= 1'b0;
    end else if (restart || !run) begin
      count <= 14'h0000;
      tick <= 1'b0;
    end else if (count == `PRESCALE_LAST) begin
      count <= 14'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 14'h0001;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: design/wdt_power_ctrl.v */
// Power mode control and keyed watchdog supervisor with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "wdt_pwr_defs.vh"

module wdt_power_ctrl (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Core side
  input wire wakeIrq,
  input wire returnFromInterrupt,
  input wire emulationMode,
  output wire cpuClockEnable,
  output wire periphClockEnable,
  output wire addressLatchHold,
  output wire wakeToService,
  output wire resumeAfterSleep,
  output reg coreReset,
  output reg chipReset,
  // Interrupt
  output wire irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [2:0] syncA;
  reg [2:0] syncB;
  wire wakeS = syncB[0];
  wire retiS = syncB[1];
  wire emuS = syncB[2];

  // Wake and return lines come from outside; two stages each
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
    end else begin
      syncA <= {emulationMode, returnFromInterrupt, wakeIrq};
      syncB <= syncA;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  reg ackQ;
  wire req = wb_cyc_i && wb_stb_i && !ackQ;
  wire wrLow = req && wb_we_i && wb_sel_i[0];
  wire rdReq = req && !wb_we_i;
  assign wb_ack_o = ackQ;

  // One-cycle registered answer; ack drops the cycle after
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ackQ <= 1'b0;
    else
      ackQ <= req;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] powerControl;
  reg [7:0] watchdogKey;
  reg [7:0] reloadValue;
  reg supervisorEnabled;
  reg [8:0] intervalLeft;
  reg [`EV_WIDTH-1:0] irqStatus;
  reg [`EV_WIDTH-1:0] irqMask;
  reg sleeping;
  reg [3:0] rstCount;

  wire wrPcon = wrLow && (wb_adr_i == `ADDR_POWER_CONTROL_REGISTER_REG);
  wire wrKey = wrLow && (wb_adr_i == `ADDR_KEY_REG);
  wire wrReload = wrLow && (wb_adr_i == `ADDR_RELOAD_REG);
  wire wrMask = wrLow && (wb_adr_i == `ADDR_IRQ_MASK);
  wire rdStat = rdReq && (wb_adr_i == `ADDR_IRQ_STAT);

  wire idleSelect = powerControl[`BIT_IDLE];
  wire powerdownSelect = powerControl[`BIT_PDOWN];
  wire reloadPermit = powerControl[`BIT_LOADEN];
  wire keyOpen = (watchdogKey != `KEY_DISABLE);
  wire dogRunning = supervisorEnabled && keyOpen;
  wire doLoad = wrReload && reloadPermit;
  wire wakeHit = wakeS && (idleSelect || powerdownSelect);
  wire expire;
  wire tick;

  // Power control: software sets modes, a wake clears both selects
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerControl <= `POWER_CONTROL_REGISTER_RESET;
    end else begin
      if (wrPcon)
        powerControl <= wb_dat_i[7:0];
      if (wakeS) begin
        powerControl[`BIT_IDLE] <= 1'b0;
        powerControl[`BIT_PDOWN] <= 1'b0;
      end
      // The hardware clear wins over a same-cycle software write
      if (doLoad)
        powerControl[`BIT_LOADEN] <= 1'b0;
    end
  end

  // Enable latch: first load-enable set arms it until reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      supervisorEnabled <= 1'b0;
    else if (wrPcon && wb_dat_i[`BIT_LOADEN])
      supervisorEnabled <= 1'b1;
  end

  // Key and reload value registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdogKey <= `KEY_RESET;
      reloadValue <= `RELOAD_RESET;
    end else begin
      if (wrKey)
        watchdogKey <= wb_dat_i[7:0];
      if (doLoad)
        reloadValue <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Watchdog count
  // ----------------------------------------------------------------
  // Count of prescaler steps left; holds while disabled or in power-down
  wire dogClock = dogRunning && !powerdownSelect;

  wdt_prescaler prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .run(dogClock),
    .restart(doLoad),
    .tick(tick)
  );

  // Interval = (256 - value) steps; reload restarts from the new value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      intervalLeft <= `COUNT_TOP;
    else if (doLoad)
      intervalLeft <= `COUNT_TOP - {1'b0, wb_dat_i[7:0]};
    else if (expire)
      intervalLeft <= `COUNT_TOP - {1'b0, reloadValue};
    else if (tick && dogClock)
      intervalLeft <= intervalLeft - 9'h001;
  end

  assign expire = dogClock && tick && (intervalLeft == 9'h001);

  // Reset pulse stretcher; emulation mode routes it to the whole chip
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstCount <= 4'h0;
      coreReset <= 1'b0;
      chipReset <= 1'b0;
    end else begin
      if (expire)
        rstCount <= `WDRST_CYCLES;
      else if (rstCount != 4'h0)
        rstCount <= rstCount - 4'h1;
      coreReset <= (expire || rstCount > 4'h1) && !emuS;
      chipReset <= (expire || rstCount > 4'h1) && emuS;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and resume tracking
  // ----------------------------------------------------------------
  // Gate enables only; state everywhere stays in its flops
  assign cpuClockEnable = !idleSelect && !powerdownSelect;
  assign periphClockEnable = !powerdownSelect;
  assign addressLatchHold = powerdownSelect;
  assign wakeToService = wakeHit;

  // Remember a wake so the return resumes past the entering instruction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sleeping <= 1'b0;
    else if (wakeHit)
      sleeping <= 1'b1;
    else if (retiS)
      sleeping <= 1'b0;
  end
  assign resumeAfterSleep = sleeping && retiS;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [`EV_WIDTH-1:0] events;
  assign events[`EV_WAKE] = wakeHit;
  assign events[`EV_WDRESET] = expire;

  genvar g;
  generate
    for (g = 0; g < `EV_WIDTH; g = g + 1) begin : evBits
      // A set in the clearing read's cycle wins
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          irqStatus[g] <= 1'b0;
        else if (events[g])
          irqStatus[g] <= 1'b1;
        else if (rdStat)
          irqStatus[g] <= 1'b0;
      end
    end
  endgenerate

  // Mask register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irqMask <= {`EV_WIDTH{1'b0}};
    else if (wrMask)
      irqMask <= wb_dat_i[`EV_WIDTH-1:0];
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses read zero and still ack
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rdReq) begin
      case (wb_adr_i)
        `ADDR_POWER_CONTROL_REGISTER_REG: wb_dat_o <= {24'h00_0000, powerControl};
        `ADDR_KEY_REG: wb_dat_o <= {24'h00_0000, watchdogKey};
        `ADDR_RELOAD_REG: wb_dat_o <= {24'h00_0000, reloadValue};
        `ADDR_STATUS_REG: wb_dat_o <= {30'h0000_0000, dogRunning, supervisorEnabled};
        `ADDR_IRQ_STAT: wb_dat_o <= {30'h0000_0000, irqStatus};
        `ADDR_IRQ_MASK: wb_dat_o <= {30'h0000_0000, irqMask};
        `ADDR_COUNT_REG: wb_dat_o <= {23'h00_0000, intervalLeft};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: test/wdt_power_ctrl_properties.sv */
// Port checker for the power mode and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wdt_power_ctrl_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core side
  input wire logic wakeIrq,
  input wire logic cpuClockEnable,
  input wire logic periphClockEnable,
  input wire logic addressLatchHold,
  input wire logic coreReset,
  input wire logic chipReset
);
  // One clock domain, so one default for every property
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus answers exactly one cycle after the request
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_follows_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
  // Sleep modes; wake margin covers the two-flop synchroniser
  a_wake_ends_sleep:
    assert property (wakeIrq [*4] |-> cpuClockEnable && periphClockEnable) else $error("no wake");
  a_pd_stops_cpu:
    assert property (!periphClockEnable |-> !cpuClockEnable) else $error("cpu clocked in pd");
  a_strobe_static:
    assert property (addressLatchHold == !periphClockEnable) else $error("strobe hold wrong");
  // Reset pulses from the supervisor
  a_core_rst_len:
    assert property ($rose(coreReset) |-> coreReset [*8] ##1 !coreReset) else $error("core len");
  a_chip_rst_len:
    assert property ($rose(chipReset) |-> chipReset [*8] ##1 !chipReset) else $error("chip len");
  a_one_reset_kind:
    assert property (!(coreReset && chipReset)) else $error("both resets");
  // Main scenarios reached
  c_idle: cover property (!cpuClockEnable && periphClockEnable);
  c_core_rst: cover property ($rose(coreReset));
  c_chip_rst: cover property ($rose(chipReset));
endmodule
bind wdt_power_ctrl wdt_power_ctrl_properties u_chk (.clk(clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wakeIrq(wakeIrq),
  .cpuClockEnable(cpuClockEnable), .periphClockEnable(periphClockEnable),
  .addressLatchHold(addressLatchHold), .coreReset(coreReset), .chipReset(chipReset));
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the power mode and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`include "wdt_pwr_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin badCount++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, wake = 0, rfi = 0, emu = 0;
  logic [5:0] adr = 0;
  logic [31:0] wdat = 0, q;
  wire logic [31:0] rdat;
  wire logic ack, cpuEn, perEn, alHold, wts, ras, coreRst, chipRst, irq;
  int badCount = 0, checks = 0, n, t0, cycleCount = 0;
  wdt_power_ctrl u_wdt_power_ctrl (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wakeIrq(wake), .returnFromInterrupt(rfi), .emulationMode(emu),
    .cpuClockEnable(cpuEn), .periphClockEnable(perEn), .addressLatchHold(alHold),
    .wakeToService(wts), .resumeAfterSleep(ras), .coreReset(coreRst), .chipReset(chipRst),
    .irq(irq));
  // 20 MHz clock and a cycle count for interval timing
  always #25 clk = ~clk;
  always @(posedge clk) cycleCount <= cycleCount + 1;
  // Classic cycle: hold until ack is sampled, then drop for a cycle
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, ack)
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK("read", {24'h00_0000, e}, q)
  endtask
  // Enter a sleep mode, wake it by interrupt, then return from service
  task automatic sleep_cycle(input logic [7:0] mode);
    wr(`ADDR_IRQ_MASK, 8'h00);
    wr(`ADDR_POWER_CONTROL_REGISTER_REG, mode);
    @(posedge clk);
    `CHK("cpuEn", 1'b0, cpuEn)
    `CHK("perEn", !mode[1], perEn)
    `CHK("alHold", mode[1], alHold)
    rd(`ADDR_POWER_CONTROL_REGISTER_REG, mode);
    wake <= 1;
    repeat (4) @(posedge clk);
    `CHK("cpuEn", 1'b1, cpuEn)
    `CHK("irq", 1'b0, irq)
    wake <= 0;
    rd(`ADDR_POWER_CONTROL_REGISTER_REG, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h01);
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    rd(`ADDR_IRQ_STAT, 8'h01);
    @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rfi <= 1;
    n = 0;
    while (ras !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    `CHK("resume", 1'b1, ras)
    rfi <= 0;
  endtask
  // Watchdog: guarded load, expiry timing, key disable, emulation reset
  task automatic watchdog_run;
    wr(`ADDR_KEY_REG, `KEY_DISABLE);
    wr(`ADDR_RELOAD_REG, 8'hFF);
    rd(`ADDR_RELOAD_REG, 8'h00);
    rd(`ADDR_STATUS_REG, 8'h00);
    wr(`ADDR_POWER_CONTROL_REGISTER_REG, 8'h10);
    wr(`ADDR_RELOAD_REG, 8'hFF);
    rd(`ADDR_STATUS_REG, 8'h01);
    wr(`ADDR_KEY_REG, 8'hA5);
    rd(`ADDR_POWER_CONTROL_REGISTER_REG, 8'h00);
    rd(`ADDR_RELOAD_REG, 8'hFF);
    rd(`ADDR_STATUS_REG, 8'h03);
    wr(`ADDR_IRQ_MASK, 8'h02);
    // Reload well inside the interval; expiry must then count from the reload
    repeat (8000) @(posedge clk);
    `CHK("early", 1'b0, coreRst)
    wr(`ADDR_POWER_CONTROL_REGISTER_REG, 8'h10);
    wr(`ADDR_RELOAD_REG, 8'hFF);
    t0 = cycleCount;
    while (coreRst !== 1'b1 && cycleCount - t0 < 13000) @(posedge clk);
    `CHK("expiry", 1'b1, (cycleCount - t0 >= 12287) && (cycleCount - t0 <= 12292))
    `CHK("chipRst", 1'b0, chipRst)
    `CHK("irq", 1'b1, irq)
    wr(`ADDR_KEY_REG, `KEY_DISABLE);
    rd(`ADDR_STATUS_REG, 8'h01);
    rd(`ADDR_IRQ_STAT, 8'h02);
    emu <= 1;
    wr(`ADDR_KEY_REG, 8'hA3);
    rd(`ADDR_STATUS_REG, 8'h03);
    t0 = cycleCount;
    while (chipRst !== 1'b1 && cycleCount - t0 < 13000) @(posedge clk);
    `CHK("chipRst", 1'b1, chipRst)
    `CHK("coreRst", 1'b0, coreRst)
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rd(`ADDR_STATUS_REG, 8'h00);
    rd(`ADDR_KEY_REG, 8'h00);
  endtask
  task automatic complete_run;
    $display("TB: checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well past two watchdog intervals
  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rd(`ADDR_POWER_CONTROL_REGISTER_REG, 8'h00);
    rd(`ADDR_KEY_REG, 8'h00);
    rd(`ADDR_RELOAD_REG, 8'h00);
    rd(6'h3C, 8'h00);
    sleep_cycle(8'h01);
    sleep_cycle(8'h02);
    watchdog_run;
    complete_run;
  end
endmodule
`default_nettype wire
